// ==== rtl/gpp_pkg.sv ====
package gpp_pkg;
    // register bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;

    // port widths
    localparam int P0_W = 4;
    localparam int P2_W = 8;
    localparam int P4_W = 8;
    localparam int P5_W = 4;
    localparam int P6_W = 7;
    localparam int P8_W = 8;
    localparam int P9_W = 4;
    localparam int KEY_W = 6;
    localparam int PIN_W = P0_W + P2_W + P4_W + P5_W + P6_W + P8_W + P9_W;

    // lsb of each port inside the packed pin vector
    localparam int P0_LSB = 0;
    localparam int P2_LSB = P0_LSB + P0_W;
    localparam int P4_LSB = P2_LSB + P2_W;
    localparam int P5_LSB = P4_LSB + P4_W;
    localparam int P6_LSB = P5_LSB + P5_W;
    localparam int P8_LSB = P6_LSB + P6_W;
    localparam int P9_LSB = P8_LSB + P8_W;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_P0 = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_P2 = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_P4 = 5'h02;
    localparam logic [ADDR_W-1:0] ADDR_P5 = 5'h03;
    localparam logic [ADDR_W-1:0] ADDR_P6 = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_P8 = 5'h05;
    localparam logic [ADDR_W-1:0] ADDR_P9 = 5'h06;
    localparam logic [ADDR_W-1:0] ADDR_M0 = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_M2 = 5'h09;
    localparam logic [ADDR_W-1:0] ADDR_M4 = 5'h0a;
    localparam logic [ADDR_W-1:0] ADDR_M5 = 5'h0b;
    localparam logic [ADDR_W-1:0] ADDR_M8 = 5'h0c;
    localparam logic [ADDR_W-1:0] ADDR_M9 = 5'h0d;
    localparam logic [ADDR_W-1:0] ADDR_PU_A = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_PU_B = 5'h11;
    localparam logic [ADDR_W-1:0] ADDR_PU_C = 5'h12;
    localparam logic [ADDR_W-1:0] ADDR_SEG8 = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_SEG9 = 5'h15;

    // reset values: mode bit 1 means input
    localparam logic [DATA_W-1:0] MODE_RESET = 8'hff;
    localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
    localparam logic [DATA_W-1:0] PU_RESET = 8'h00;
    localparam logic [DATA_W-1:0] SEG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;

    // pull-up option bit positions
    localparam int PU_A_P0_BIT = 0;
    localparam int PU_A_P4_BIT = 4;
    localparam int PU_B_P2_BIT = 2;
    localparam int PU_C_P8_BIT = 0;
    localparam int PU_C_P9_BIT = 1;
endpackage

// ==== rtl/gpp_port_pins.sv ====
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/10ps
module gpp_port_pins #(
    parameter int MASK_ROM_VARIANT = 0,
    parameter logic [gpp_pkg::P5_W-1:0] OD_MASK_PULLUP = 4'h0
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // register port
    input wire logic [gpp_pkg::ADDR_W-1:0] i_addr,
    input wire logic [gpp_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [gpp_pkg::DATA_W-1:0] o_rdata,
    // first port pins
    input wire logic [gpp_pkg::P0_W-1:0] i_first_port_pins,
    output logic [gpp_pkg::P0_W-1:0] o_first_port_pins,
    output logic [gpp_pkg::P0_W-1:0] o_first_port_pins_oe_b,
    output logic [gpp_pkg::P0_W-1:0] o_first_port_pins_pullup,
    // second port pins
    input wire logic [gpp_pkg::P2_W-1:0] i_second_port_pins,
    output logic [gpp_pkg::P2_W-1:0] o_second_port_pins,
    output logic [gpp_pkg::P2_W-1:0] o_second_port_pins_oe_b,
    output logic [gpp_pkg::P2_W-1:0] o_second_port_pins_pullup,
    output logic [gpp_pkg::P2_W-1:0] o_second_port_in,
    // fourth port pins and key return
    input wire logic [gpp_pkg::P4_W-1:0] i_fourth_port_pins,
    output logic [gpp_pkg::P4_W-1:0] o_fourth_port_pins,
    output logic [gpp_pkg::P4_W-1:0] o_fourth_port_pins_oe_b,
    output logic [gpp_pkg::P4_W-1:0] o_fourth_port_pins_pullup,
    output logic [gpp_pkg::KEY_W-1:0] o_key_return_inputs,
    // open-drain port pins
    input wire logic [gpp_pkg::P5_W-1:0] i_open_drain_port_pins,
    output logic [gpp_pkg::P5_W-1:0] o_open_drain_port_pins,
    output logic [gpp_pkg::P5_W-1:0] o_open_drain_port_pins_oe_b,
    output logic [gpp_pkg::P5_W-1:0] o_open_drain_port_pins_pullup,
    // analog-shared input port
    input wire logic [gpp_pkg::P6_W-1:0] i_analog_port_pins,
    output logic [gpp_pkg::P6_W-1:0] o_analog_port_in,
    // eighth and ninth port pins with segment sources
    input wire logic [gpp_pkg::P8_W-1:0] i_eighth_port_pins,
    input wire logic [gpp_pkg::P8_W-1:0] i_segment_outputs_high,
    output logic [gpp_pkg::P8_W-1:0] o_eighth_port_pins,
    output logic [gpp_pkg::P8_W-1:0] o_eighth_port_pins_oe_b,
    output logic [gpp_pkg::P8_W-1:0] o_eighth_port_pins_pullup,
    input wire logic [gpp_pkg::P9_W-1:0] i_ninth_port_pins,
    input wire logic [gpp_pkg::P9_W-1:0] i_segment_outputs_mid,
    output logic [gpp_pkg::P9_W-1:0] o_ninth_port_pins,
    output logic [gpp_pkg::P9_W-1:0] o_ninth_port_pins_oe_b,
    output logic [gpp_pkg::P9_W-1:0] o_ninth_port_pins_pullup
);

    // elaboration check on the variant switch
    if (MASK_ROM_VARIANT != 0 && MASK_ROM_VARIANT != 1) begin : g_bad_variant
        $error("MASK_ROM_VARIANT must be 0 or 1");
    end

    // per port: output latch, mode (1 = input), synchronised pin view; the analog port has only the pin view
    logic [gpp_pkg::P0_W-1:0] latch0, mode0, sync0;
    logic [gpp_pkg::P2_W-1:0] latch2, mode2, sync2;
    logic [gpp_pkg::P4_W-1:0] latch4, mode4, sync4;
    logic [gpp_pkg::P5_W-1:0] latch5, mode5, sync5;
    logic [gpp_pkg::P6_W-1:0] sync6;
    // segment select, 1 = segment source drives the pin
    logic [gpp_pkg::P8_W-1:0] latch8, mode8, sync8, seg8;
    logic [gpp_pkg::P9_W-1:0] latch9, mode9, sync9, seg9;
    // pull-up options and read mux value
    logic [gpp_pkg::DATA_W-1:0] pullup_select_a, pullup_select_b;
    logic [gpp_pkg::DATA_W-1:0] pullup_select_c, next_rdata;
    // pin synchroniser
    logic [gpp_pkg::PIN_W-1:0] pin_meta, pin_sync, pin_raw;

    function automatic logic wr_at(input logic [gpp_pkg::ADDR_W-1:0] a);
        wr_at = i_wr && (i_addr == a);
    endfunction

    // pin vector; pins are asynchronous to the core clock
    assign pin_raw = {i_ninth_port_pins, i_eighth_port_pins,
                      i_analog_port_pins, i_open_drain_port_pins,
                      i_fourth_port_pins, i_second_port_pins,
                      i_first_port_pins};

    // two-stage synchroniser, first stage read only by second
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    assign sync0 = pin_sync[gpp_pkg::P0_LSB +: gpp_pkg::P0_W];
    assign sync2 = pin_sync[gpp_pkg::P2_LSB +: gpp_pkg::P2_W];
    assign sync4 = pin_sync[gpp_pkg::P4_LSB +: gpp_pkg::P4_W];
    assign sync5 = pin_sync[gpp_pkg::P5_LSB +: gpp_pkg::P5_W];
    assign sync6 = pin_sync[gpp_pkg::P6_LSB +: gpp_pkg::P6_W];
    assign sync8 = pin_sync[gpp_pkg::P8_LSB +: gpp_pkg::P8_W];
    assign sync9 = pin_sync[gpp_pkg::P9_LSB +: gpp_pkg::P9_W];

    // output latches, written at the port offsets
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            latch0 <= gpp_pkg::LATCH_RESET[gpp_pkg::P0_W-1:0];
            latch2 <= gpp_pkg::LATCH_RESET[gpp_pkg::P2_W-1:0];
            latch4 <= gpp_pkg::LATCH_RESET[gpp_pkg::P4_W-1:0];
            latch5 <= gpp_pkg::LATCH_RESET[gpp_pkg::P5_W-1:0];
            latch8 <= gpp_pkg::LATCH_RESET[gpp_pkg::P8_W-1:0];
            latch9 <= gpp_pkg::LATCH_RESET[gpp_pkg::P9_W-1:0];
        end else begin
            if (wr_at(gpp_pkg::ADDR_P0)) latch0 <= i_wdata[gpp_pkg::P0_W-1:0];
            if (wr_at(gpp_pkg::ADDR_P2)) latch2 <= i_wdata[gpp_pkg::P2_W-1:0];
            if (wr_at(gpp_pkg::ADDR_P4)) latch4 <= i_wdata[gpp_pkg::P4_W-1:0];
            if (wr_at(gpp_pkg::ADDR_P5)) latch5 <= i_wdata[gpp_pkg::P5_W-1:0];
            if (wr_at(gpp_pkg::ADDR_P8)) latch8 <= i_wdata[gpp_pkg::P8_W-1:0];
            if (wr_at(gpp_pkg::ADDR_P9)) latch9 <= i_wdata[gpp_pkg::P9_W-1:0];
        end
    end

    // per-pin direction; all inputs out of reset
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode0 <= gpp_pkg::MODE_RESET[gpp_pkg::P0_W-1:0];
            mode2 <= gpp_pkg::MODE_RESET[gpp_pkg::P2_W-1:0];
            mode4 <= gpp_pkg::MODE_RESET[gpp_pkg::P4_W-1:0];
            mode5 <= gpp_pkg::MODE_RESET[gpp_pkg::P5_W-1:0];
            mode8 <= gpp_pkg::MODE_RESET[gpp_pkg::P8_W-1:0];
            mode9 <= gpp_pkg::MODE_RESET[gpp_pkg::P9_W-1:0];
        end else begin
            if (wr_at(gpp_pkg::ADDR_M0)) mode0 <= i_wdata[gpp_pkg::P0_W-1:0];
            if (wr_at(gpp_pkg::ADDR_M2)) mode2 <= i_wdata[gpp_pkg::P2_W-1:0];
            if (wr_at(gpp_pkg::ADDR_M4)) mode4 <= i_wdata[gpp_pkg::P4_W-1:0];
            if (wr_at(gpp_pkg::ADDR_M5)) mode5 <= i_wdata[gpp_pkg::P5_W-1:0];
            if (wr_at(gpp_pkg::ADDR_M8)) mode8 <= i_wdata[gpp_pkg::P8_W-1:0];
            if (wr_at(gpp_pkg::ADDR_M9)) mode9 <= i_wdata[gpp_pkg::P9_W-1:0];
        end
    end

    // pull-up options and segment selects
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pullup_select_a <= gpp_pkg::PU_RESET;
            pullup_select_b <= gpp_pkg::PU_RESET;
            pullup_select_c <= gpp_pkg::PU_RESET;
            seg8 <= gpp_pkg::SEG_RESET[gpp_pkg::P8_W-1:0];
            seg9 <= gpp_pkg::SEG_RESET[gpp_pkg::P9_W-1:0];
        end else begin
            if (wr_at(gpp_pkg::ADDR_PU_A)) pullup_select_a <= i_wdata;
            if (wr_at(gpp_pkg::ADDR_PU_B)) pullup_select_b <= i_wdata;
            if (wr_at(gpp_pkg::ADDR_PU_C)) pullup_select_c <= i_wdata;
            if (wr_at(gpp_pkg::ADDR_SEG8)) seg8 <= i_wdata[gpp_pkg::P8_W-1:0];
            if (wr_at(gpp_pkg::ADDR_SEG9)) seg9 <= i_wdata[gpp_pkg::P9_W-1:0];
        end
    end

    // push-pull drivers; oe_b low while the pin is driven
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_first_port_pins <= '0;
            o_first_port_pins_oe_b <= '1;
            o_second_port_pins <= '0;
            o_second_port_pins_oe_b <= '1;
            o_fourth_port_pins <= '0;
            o_fourth_port_pins_oe_b <= '1;
        end else begin
            o_first_port_pins <= latch0;
            o_first_port_pins_oe_b <= mode0;
            o_second_port_pins <= latch2;
            o_second_port_pins_oe_b <= mode2;
            o_fourth_port_pins <= latch4;
            o_fourth_port_pins_oe_b <= mode4;
        end
    end

    // segment select overrides latch and direction
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_eighth_port_pins <= '0;
            o_eighth_port_pins_oe_b <= '1;
            o_ninth_port_pins <= '0;
            o_ninth_port_pins_oe_b <= '1;
        end else begin
            o_eighth_port_pins <= (seg8 & i_segment_outputs_high)
                                | (~seg8 & latch8);
            o_eighth_port_pins_oe_b <= mode8 & ~seg8;
            o_ninth_port_pins <= (seg9 & i_segment_outputs_mid)
                               | (~seg9 & latch9);
            o_ninth_port_pins_oe_b <= mode9 & ~seg9;
        end
    end

    // open-drain: only ever pulls low, released otherwise
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_open_drain_port_pins <= '0;
            o_open_drain_port_pins_oe_b <= '1;
        end else begin
            o_open_drain_port_pins <= '0;
            o_open_drain_port_pins_oe_b <= mode5 | latch5;
        end
    end

    // pull-ups: enabled only on pins that are inputs
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_first_port_pins_pullup <= '0;
            o_second_port_pins_pullup <= '0;
            o_fourth_port_pins_pullup <= '0;
            o_eighth_port_pins_pullup <= '0;
            o_ninth_port_pins_pullup <= '0;
            o_open_drain_port_pins_pullup <= '0;
        end else begin
            o_first_port_pins_pullup <= mode0
                & {gpp_pkg::P0_W{pullup_select_a[gpp_pkg::PU_A_P0_BIT]}};
            o_fourth_port_pins_pullup <= mode4
                & {gpp_pkg::P4_W{pullup_select_a[gpp_pkg::PU_A_P4_BIT]}};
            o_second_port_pins_pullup <= mode2
                & {gpp_pkg::P2_W{pullup_select_b[gpp_pkg::PU_B_P2_BIT]}};
            // a segment pin is an output, so its pull-up drops
            o_eighth_port_pins_pullup <= mode8 & ~seg8
                & {gpp_pkg::P8_W{pullup_select_c[gpp_pkg::PU_C_P8_BIT]}};
            o_ninth_port_pins_pullup <= mode9 & ~seg9
                & {gpp_pkg::P9_W{pullup_select_c[gpp_pkg::PU_C_P9_BIT]}};
            // mask fixed at build time and gated by mode5; no pull-up option bit reaches it
            o_open_drain_port_pins_pullup <= (MASK_ROM_VARIANT == 1) ?
                (mode5 & OD_MASK_PULLUP) : '0;
        end
    end

    // digital views handed to peripherals
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_second_port_in <= '0;
            o_key_return_inputs <= '0;
            o_analog_port_in <= '0;
        end else begin
            o_second_port_in <= sync2;
            o_key_return_inputs <= sync4[gpp_pkg::KEY_W-1:0];
            o_analog_port_in <= sync6;
        end
    end

    // read mux: inputs show the pin, outputs show the latch
    always_comb begin
        next_rdata = gpp_pkg::READ_IDLE;
        if (i_rd) begin
            unique case (i_addr)
                gpp_pkg::ADDR_P0: next_rdata = 8'((sync0 & mode0) | (latch0 & ~mode0));
                gpp_pkg::ADDR_P2: next_rdata = (sync2 & mode2) | (latch2 & ~mode2);
                gpp_pkg::ADDR_P4: next_rdata = (sync4 & mode4) | (latch4 & ~mode4);
                gpp_pkg::ADDR_P5: next_rdata = 8'((sync5 & mode5) | (latch5 & ~mode5));
                gpp_pkg::ADDR_P6: next_rdata = 8'(sync6);
                gpp_pkg::ADDR_P8: next_rdata = (sync8 & mode8) | (latch8 & ~mode8);
                gpp_pkg::ADDR_P9: next_rdata = 8'((sync9 & mode9) | (latch9 & ~mode9));
                gpp_pkg::ADDR_M0: next_rdata = 8'(mode0);
                gpp_pkg::ADDR_M2: next_rdata = mode2;
                gpp_pkg::ADDR_M4: next_rdata = mode4;
                gpp_pkg::ADDR_M5: next_rdata = 8'(mode5);
                gpp_pkg::ADDR_M8: next_rdata = mode8;
                gpp_pkg::ADDR_M9: next_rdata = 8'(mode9);
                gpp_pkg::ADDR_PU_A: next_rdata = pullup_select_a;
                gpp_pkg::ADDR_PU_B: next_rdata = pullup_select_b;
                gpp_pkg::ADDR_PU_C: next_rdata = pullup_select_c;
                gpp_pkg::ADDR_SEG8: next_rdata = seg8;
                gpp_pkg::ADDR_SEG9: next_rdata = 8'(seg9);
                default: next_rdata = gpp_pkg::READ_IDLE; // unmapped reads zero
            endcase
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= gpp_pkg::READ_IDLE;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    property p_first_dir;
        wr_at(gpp_pkg::ADDR_M0) |-> ##2
            (o_first_port_pins_oe_b == $past(i_wdata[gpp_pkg::P0_W-1:0], 2));
    endproperty
    a_first_dir: assert property (p_first_dir)
        else $error("first port direction not applied");
    property p_second_dir;
        wr_at(gpp_pkg::ADDR_M2) |-> ##2
            (o_second_port_pins_oe_b == $past(i_wdata, 2));
    endproperty
    a_second_dir: assert property (p_second_dir)
        else $error("second port direction not applied");

    property p_key_return;
        o_key_return_inputs == $past(sync4[gpp_pkg::KEY_W-1:0]);
    endproperty
    a_key_return: assert property (p_key_return)
        else $error("key return does not follow fourth port");
    property p_open_drain;
        (o_open_drain_port_pins == '0) &&
        ((~o_open_drain_port_pins_oe_b & ($past(latch5) | $past(mode5))) == '0);
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain pin driven high or while input");

    property p_pullup_input;
        ((o_eighth_port_pins_pullup & ~o_eighth_port_pins_oe_b) == '0) &&
        ((o_first_port_pins_pullup & ~o_first_port_pins_oe_b) == '0);
    endproperty
    a_pullup_input: assert property (p_pullup_input)
        else $error("pull-up on a driven pin");
    // pull-up follows the mode of each fourth-port pin once the option is set
    property p_pullup_a;
        wr_at(gpp_pkg::ADDR_PU_A) && i_wdata[gpp_pkg::PU_A_P4_BIT]
            && !wr_at(gpp_pkg::ADDR_M4)
            ##1 !wr_at(gpp_pkg::ADDR_PU_A) && !wr_at(gpp_pkg::ADDR_M4)
            |-> ##1 (o_fourth_port_pins_pullup == $past(mode4));
    endproperty
    a_pullup_a: assert property (p_pullup_a)
        else $error("fourth port pull-up missing");

    property p_pullup_b;
        !pullup_select_b[gpp_pkg::PU_B_P2_BIT] |=> (o_second_port_pins_pullup == '0);
    endproperty
    a_pullup_b: assert property (p_pullup_b)
        else $error("second port pull-up without enable");
    property p_pullup_c;
        !pullup_select_c[gpp_pkg::PU_C_P9_BIT] |=> (o_ninth_port_pins_pullup == '0);
    endproperty
    a_pullup_c: assert property (p_pullup_c)
        else $error("ninth port pull-up without enable");

    property p_segment;
        (seg8 == '1) |=> (o_eighth_port_pins == $past(i_segment_outputs_high))
            && (o_eighth_port_pins_oe_b == '0);
    endproperty
    a_segment: assert property (p_segment)
        else $error("segment output not on eighth port");
    property p_analog_read;
        i_rd && (i_addr == gpp_pkg::ADDR_P6) |=> (o_rdata == 8'($past(sync6)));
    endproperty
    a_analog_read: assert property (p_analog_read)
        else $error("sixth port read wrong");

    c_dir_out: cover property (wr_at(gpp_pkg::ADDR_M0) && i_wdata == 8'h00);
    c_seg_on: cover property (wr_at(gpp_pkg::ADDR_SEG9) ##2 !o_ninth_port_pins_oe_b[0]);
    c_od_low: cover property (o_open_drain_port_pins_oe_b != '1);
    c_read_p6: cover property (i_rd && i_addr == gpp_pkg::ADDR_P6);

endmodule

// ==== tb/gpp_board.sv ====
`timescale 1ns/10ps
// board model: each pin resolved from device drive, board drive, pull-up
module gpp_board #(
    parameter int W = 8
) (
    // clock for the floating pattern
    input wire logic i_core_clk,
    // device side
    input wire logic [W-1:0] i_out,
    input wire logic [W-1:0] i_oe_b,
    input wire logic [W-1:0] i_pu,
    // board drivers
    input wire logic [W-1:0] i_ext,
    input wire logic [W-1:0] i_ext_en,
    // resolved pin level
    output logic [W-1:0] o_pin
);
    logic [W-1:0] flt = '0;
    // a floating pin toggles so it never passes for a pulled level
    always_ff @(posedge i_core_clk) begin
        flt <= ~flt;
    end
    // device drive wins, then board drive, then pull-up
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!i_oe_b[i]) o_pin[i] = i_out[i];
            else if (i_ext_en[i]) o_pin[i] = i_ext[i];
            else if (i_pu[i]) o_pin[i] = 1'h1;
            else o_pin[i] = flt[i];
        end
    end
endmodule

// ==== tb/gpp_port_pins_tb_top.sv ====
`timescale 1ns/10ps
module gpp_port_pins_tb_top;
    logic i_core_clk = 1'h0, i_rst_b = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
    logic [4:0] i_addr = 5'h00;
    logic [7:0] i_wdata = 8'h00, o_rdata, seg_hi = 8'h00;
    logic [3:0] seg_mid = 4'h0, o0, oe0, pu0, o5, oe5, pu5, o9, oe9, pu9;
    logic [7:0] o2, oe2, pu2, o4, oe4, pu4, o8, oe8, pu8, sec_in;
    logic [6:0] ana = 7'h00, ana_in;
    logic [5:0] key;
    logic [47:0] out_v, oe_v, pu_v, pin_v, ext_v = '1, en_v = '1;
    int error_cnt = 0, checked = 0;
    logic [4:0] pa[6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06};
    logic [4:0] ma[6] = '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d};
    logic [7:0] wm[6] = '{8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h0f};
    logic [4:0] pua[3] = '{5'h10, 5'h11, 5'h12};
    logic [7:0] puv[3] = '{8'h11, 8'h04, 8'h03};
    logic [5:0] pum[3] = '{6'h05, 6'h02, 6'h30};
    // ports packed at 8-bit strides; pads never drive
    assign out_v = {4'h0, o9, o8, 4'h0, o5, o4, o2, 4'h0, o0};
    assign oe_v = {4'hf, oe9, oe8, 4'hf, oe5, oe4, oe2, 4'hf, oe0};
    assign pu_v = {4'h0, pu9, pu8, 4'h0, pu5, pu4, pu2, 4'h0, pu0};
    always #5 i_core_clk = ~i_core_clk;
    gpp_board #(.W(48)) u_board (.i_core_clk(i_core_clk), .i_out(out_v),
        .i_oe_b(oe_v), .i_pu(pu_v), .i_ext(ext_v), .i_ext_en(en_v),
        .o_pin(pin_v));
    gpp_port_pins u_dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_first_port_pins(pin_v[3:0]),
        .o_first_port_pins(o0), .o_first_port_pins_oe_b(oe0),
        .o_first_port_pins_pullup(pu0), .i_second_port_pins(pin_v[15:8]),
        .o_second_port_pins(o2), .o_second_port_pins_oe_b(oe2),
        .o_second_port_pins_pullup(pu2), .o_second_port_in(sec_in),
        .i_fourth_port_pins(pin_v[23:16]), .o_fourth_port_pins(o4),
        .o_fourth_port_pins_oe_b(oe4), .o_fourth_port_pins_pullup(pu4),
        .o_key_return_inputs(key), .i_open_drain_port_pins(pin_v[27:24]),
        .o_open_drain_port_pins(o5), .o_open_drain_port_pins_oe_b(oe5),
        .o_open_drain_port_pins_pullup(pu5), .i_analog_port_pins(ana),
        .o_analog_port_in(ana_in), .i_eighth_port_pins(pin_v[39:32]),
        .i_segment_outputs_high(seg_hi), .o_eighth_port_pins(o8),
        .o_eighth_port_pins_oe_b(oe8), .o_eighth_port_pins_pullup(pu8),
        .i_ninth_port_pins(pin_v[43:40]), .i_segment_outputs_mid(seg_mid),
        .o_ninth_port_pins(o9), .o_ninth_port_pins_oe_b(oe9),
        .o_ninth_port_pins_pullup(pu9));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'h1;
        @(posedge i_core_clk);
        i_wr <= 1'h0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'h1;
        @(posedge i_core_clk);
        i_rd <= 1'h0;
        #1;
        chk(o_rdata, exp);
    endtask
    // pins pass two sync stages plus an output register
    task automatic settle();
        repeat (5) @(posedge i_core_clk);
        #1;
    endtask
    task automatic close_out();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200us;
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge i_core_clk);
        i_rst_b <= 1'h1;
        #1;
        for (int k = 0; k < 6; k++) begin
            chk(oe_v[k*8+:8], 8'hff);
            chk(pu_v[k*8+:8], 8'h00);
            rd(ma[k], wm[k]);
        end
        $display("test reset done");
        for (int k = 0; k < 6; k++) begin
            if (k == 3) continue;
            wr(ma[k], 8'h5a);
            wr(pa[k], 8'h33);
            settle();
            chk(oe_v[k*8+:8], (8'h5a & wm[k]) | ~wm[k]);
            chk(out_v[k*8+:8] & 8'ha5 & wm[k], 8'h21 & wm[k]);
            rd(pa[k], 8'h7b & wm[k]);
        end
        chk({2'h0, key}, 8'h3b);
        chk(sec_in, 8'h7b);
        $display("test direction done");
        en_v <= '0;
        for (int r = 0; r < 3; r++) begin
            wr(pua[r], puv[r]);
            settle();
            for (int k = 0; k < 6; k++) begin
                chk(pu_v[k*8+:8], pum[r][k] ? 8'h5a & wm[k] : 8'h00);
                if (pum[r][k]) rd(pa[k], 8'h7b & wm[k]);
            end
            rd(pua[r], puv[r]);
            wr(pua[r], 8'h00);
        end
        en_v <= '1;
        $display("test pullup done");
        wr(ma[3], 8'h00);
        wr(pa[3], 8'h03);
        wr(pua[2], 8'h03);
        seg_hi <= 8'ha5;
        seg_mid <= 4'h9;
        wr(5'h14, 8'hff);
        wr(5'h15, 8'h0f);
        settle();
        chk({oe5, o5}, 8'h30);
        chk({4'h0, pu5}, 8'h00);
        rd(pa[3], 8'h03);
        chk(o8, 8'ha5);
        chk({oe9, o9}, 8'h09);
        chk(oe8 | pu8, 8'h00);
        chk({4'h0, pu9}, 8'h00);
        $display("test drain segment done");
        ana <= 7'h55;
        wr(5'h04, 8'h00);
        settle();
        chk({1'h0, ana_in}, 8'h55);
        rd(5'h04, 8'h55);
        rd(5'h1f, 8'h00);
        $display("test analog done");
        close_out();
    end
endmodule
